/* common/scou_map.svh */
// register offsets, field positions and reset values of the compare unit
`ifndef SCOU_MAP_SVH
`define SCOU_MAP_SVH
`define SCOU_OFF_CTRL1 12'h000
`define SCOU_OFF_CTRL2 12'h004
`define SCOU_OFF_PRIM 12'h008
`define SCOU_OFF_SEC 12'h00c
`define SCOU_OFF_TIMER 12'h010
`define SCOU_OFF_STAT 12'h014
`define SCOU_MODE_LSB 0
`define SCOU_SEL_LSB 0
`define SCOU_TRIGSTAT_BIT 6
`define SCOU_TRIGSEL_BIT 7
`define SCOU_FLAG_BIT 0
`define SCOU_OUT_BIT 1
`define SCOU_SEL_NONE 5'h00
`define SCOU_SEL_SELF 5'h1f
`define SCOU_RST_WORD 32'h0000_0000
`endif

/* common/scou_pkg.sv */
// types shared by the compare unit
package scou_pkg;
  typedef enum logic [2:0] {
    MODE_OFF = 3'h0,
    MODE_SET_HIGH = 3'h1,
    MODE_SET_LOW = 3'h2,
    MODE_TOGGLE = 3'h3
  } scou_mode_e;

  typedef enum logic {
    TRG_HELD = 1'h0,
    TRG_RUN = 1'h1
  } scou_trig_e;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } scou_apb_req_s;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } scou_apb_rsp_s;
endpackage

/* logic/scou_unit.sv */
// single compare output channel with apb registers and own timer
// How it works
// [R1] sync pulse clears the timer
// [R2] trigger mode holds timer until pulse
// [R3] one bit picks sync or trigger
// [R4] bit one means trigger, zero sync
// [R5] selector zero: free-running timer
// [R6] selector all ones: reset at secondary
// [R7] sync pulse out at secondary match
// [R8] mode 001: low, then high on match
// [R9] mode 010: high, then low on match
// [R10] mode 011: low, toggle every match
// [R11] mode 000 disables the channel
// [R12] flag only when output level changes
// [R13] pin changes one clock after match
// [R14] set level holds until mode change
// [R15] timer counts up, clears next clock
// [R16] flag two clocks after pin change
// [R17] output resets low; software sets toggle
// [R18] primary beyond period: no event
// [R19] primary equal period: normal match
// [R20] held timer with zero primary: no event
// [R21] cleared primary after event: no change
// [R22] one equality match per clock
//
// Design decisions made here: register access over APB and the register offsets.
`include "scou_map.svh"

module scou_unit #(
  parameter int TW = 16,
  parameter int NSRC = 32
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire scou_pkg::scou_apb_req_s apb_req_i,
  output scou_pkg::scou_apb_rsp_s apb_rsp_o,
  input wire logic [NSRC-1:0] peer_sync_i,
  output logic compare_output_pin_o,
  output logic channel_interrupt_flag_o,
  output logic sync_out_o
);

  // apb decode
  function automatic logic hit(input logic [11:0] a,
                               input logic [11:0] off);
    hit = (a == off);
  endfunction

  scou_pkg::scou_apb_rsp_s rsp_q;
  scou_pkg::scou_mode_e compare_mode_code_q;
  scou_pkg::scou_trig_e trig_q;
  logic [4:0] sync_source_select_q;
  logic trigger_not_sync_select_q;
  logic [TW-1:0] primary_compare_value_q;
  logic [TW-1:0] secondary_compare_value_q;
  logic [TW-1:0] channel_timer_q;
  logic [TW-1:0] channel_timer_d;
  logic out_q;
  logic chg1_q;
  logic chg2_q;
  logic flag_q;
  logic sync_out_q;
  logic [NSRC-1:0] ps1_q;
  logic [NSRC-1:0] ps2_q;

  logic setup;
  logic wr_en;
  logic wr_ctrl1;
  logic wr_ctrl2;
  logic wr_stat;
  logic mapped;
  logic running;
  logic own_eq;
  logic sync_evt;
  logic match;
  logic new_out;
  logic chg;
  logic sw_out;
  logic [31:0] rd_word;

  assign setup = apb_req_i.psel && !apb_req_i.penable;
  // write lands in the access cycle, the one the master samples
  assign wr_en = apb_req_i.psel && apb_req_i.penable &&
                 rsp_q.pready && apb_req_i.pwrite;
  assign wr_ctrl1 = wr_en && hit(apb_req_i.paddr, `SCOU_OFF_CTRL1);
  assign wr_ctrl2 = wr_en && hit(apb_req_i.paddr, `SCOU_OFF_CTRL2);
  assign wr_stat = wr_en && hit(apb_req_i.paddr, `SCOU_OFF_STAT);

  assign mapped = hit(apb_req_i.paddr, `SCOU_OFF_CTRL1) ||
                  hit(apb_req_i.paddr, `SCOU_OFF_CTRL2) ||
                  hit(apb_req_i.paddr, `SCOU_OFF_PRIM) ||
                  hit(apb_req_i.paddr, `SCOU_OFF_SEC) ||
                  hit(apb_req_i.paddr, `SCOU_OFF_TIMER) ||
                  hit(apb_req_i.paddr, `SCOU_OFF_STAT);

  always_comb begin
    rd_word = `SCOU_RST_WORD;
    case (apb_req_i.paddr)
      `SCOU_OFF_CTRL1: begin
        rd_word[`SCOU_MODE_LSB +: 3] = compare_mode_code_q;
      end
      `SCOU_OFF_CTRL2: begin
        rd_word[`SCOU_SEL_LSB +: 5] = sync_source_select_q;
        rd_word[`SCOU_TRIGSTAT_BIT] = trig_q;
        rd_word[`SCOU_TRIGSEL_BIT] = trigger_not_sync_select_q;
      end
      `SCOU_OFF_PRIM: begin
        rd_word[TW-1:0] = primary_compare_value_q;
      end
      `SCOU_OFF_SEC: begin
        rd_word[TW-1:0] = secondary_compare_value_q;
      end
      `SCOU_OFF_TIMER: begin
        rd_word[TW-1:0] = channel_timer_q;
      end
      `SCOU_OFF_STAT: begin
        rd_word[`SCOU_FLAG_BIT] = flag_q;
        rd_word[`SCOU_OUT_BIT] = out_q;
      end
      default: begin
        rd_word = `SCOU_RST_WORD;
      end
    endcase
  end

  // zero wait: ready rises for the first access cycle only
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rsp_q <= '0;
    end else begin
      rsp_q.pready <= setup;
      if (setup) begin
        rsp_q.prdata <= apb_req_i.pwrite ? `SCOU_RST_WORD : rd_word;
        rsp_q.pslverr <= !mapped;
      end
    end
  end

  // control registers
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      compare_mode_code_q <= scou_pkg::MODE_OFF;
      sync_source_select_q <= `SCOU_SEL_NONE;
      trigger_not_sync_select_q <= 1'h0;
    end else begin
      if (wr_ctrl1) begin
        // dual-compare and pwm codes are not built; they read as off
        compare_mode_code_q <=
          (apb_req_i.pwdata[`SCOU_MODE_LSB +: 3] > 3'h3) ?
          scou_pkg::MODE_OFF :
          scou_pkg::scou_mode_e'(apb_req_i.pwdata[`SCOU_MODE_LSB +: 3]);
      end
      if (wr_ctrl2) begin
        sync_source_select_q <= apb_req_i.pwdata[`SCOU_SEL_LSB +: 5];
        trigger_not_sync_select_q <=
          apb_req_i.pwdata[`SCOU_TRIGSEL_BIT]; // [R3]
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      primary_compare_value_q <= '0;
      secondary_compare_value_q <= '0;
    end else begin
      if (wr_en && hit(apb_req_i.paddr, `SCOU_OFF_PRIM)) begin
        primary_compare_value_q <= apb_req_i.pwdata[TW-1:0];
      end
      if (wr_en && hit(apb_req_i.paddr, `SCOU_OFF_SEC)) begin
        secondary_compare_value_q <= apb_req_i.pwdata[TW-1:0];
      end
    end
  end

  // peer pulses come from elsewhere, so two flops first
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ps1_q <= '0;
      ps2_q <= '0;
    end else begin
      ps1_q <= peer_sync_i;
      ps2_q <= ps1_q;
    end
  end

  assign own_eq = (channel_timer_q == secondary_compare_value_q);

  always_comb begin
    case (sync_source_select_q)
      `SCOU_SEL_NONE: sync_evt = 1'h0; // [R5]
      `SCOU_SEL_SELF: sync_evt = own_eq; // [R6]
      default: sync_evt = ps2_q[sync_source_select_q];
    endcase
  end

  // trigger status: the event wins over a software clear
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      trig_q <= scou_pkg::TRG_HELD;
    end else begin
      case (trig_q)
        scou_pkg::TRG_HELD: begin
          if (trigger_not_sync_select_q && sync_evt) begin
            trig_q <= scou_pkg::TRG_RUN; // [R2] [R4]
          end
        end
        scou_pkg::TRG_RUN: begin
          if (wr_ctrl2 && !apb_req_i.pwdata[`SCOU_TRIGSTAT_BIT] &&
              !(trigger_not_sync_select_q && sync_evt)) begin
            trig_q <= scou_pkg::TRG_HELD;
          end
        end
        default: trig_q <= scou_pkg::TRG_HELD;
      endcase
    end
  end

  assign running = (compare_mode_code_q != scou_pkg::MODE_OFF) &&
                   (!trigger_not_sync_select_q ||
                    trig_q == scou_pkg::TRG_RUN); // [R2] [R11]

  always_comb begin
    if (!running) begin
      channel_timer_d = '0; // [R2]
    end else if (!trigger_not_sync_select_q && sync_evt) begin
      channel_timer_d = '0; // [R1] [R4] [R15]
    end else begin
      channel_timer_d = channel_timer_q + 1'b1; // [R15]
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      channel_timer_q <= '0;
    end else begin
      channel_timer_q <= channel_timer_d;
    end
  end

  // plain equality; a value past the period never matches
  assign match = running &&
                 (channel_timer_q == primary_compare_value_q); // [R22] [R18] [R19] [R20]

  always_comb begin
    case (compare_mode_code_q)
      scou_pkg::MODE_SET_HIGH: new_out = 1'h1; // [R8]
      scou_pkg::MODE_SET_LOW: new_out = 1'h0; // [R9]
      scou_pkg::MODE_TOGGLE: new_out = !out_q; // [R10]
      default: new_out = out_q;
    endcase
  end

  assign chg = match && (new_out != out_q); // [R12]
  // only a write that really sets the level may swallow the flag
  assign sw_out = wr_ctrl1 ||
                  (wr_stat && compare_mode_code_q == scou_pkg::MODE_TOGGLE);

  // output level; a mode write sets the starting level
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      out_q <= 1'h0; // [R17]
    end else if (wr_ctrl1) begin
      out_q <= (apb_req_i.pwdata[`SCOU_MODE_LSB +: 3] ==
                scou_pkg::MODE_SET_LOW); // [R8] [R9] [R10]
    end else if (wr_stat &&
                 compare_mode_code_q == scou_pkg::MODE_TOGGLE) begin
      out_q <= apb_req_i.pwdata[`SCOU_OUT_BIT]; // [R17]
    end else if (chg) begin
      out_q <= new_out; // [R13] [R14] [R21]
    end
  end

  // two-stage delay from pin change to flag
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      chg1_q <= 1'h0;
      chg2_q <= 1'h0;
    end else begin
      chg1_q <= chg && !sw_out;
      chg2_q <= chg1_q;
    end
  end

  // flag: write one to clear, a same-cycle set wins
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      flag_q <= 1'h0;
    end else if (chg2_q) begin
      flag_q <= 1'h1; // [R16] [R12]
    end else if (wr_stat && apb_req_i.pwdata[`SCOU_FLAG_BIT]) begin
      flag_q <= 1'h0;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sync_out_q <= 1'h0;
    end else begin
      sync_out_q <= running && own_eq; // [R7]
    end
  end

  assign apb_rsp_o = rsp_q;
  assign compare_output_pin_o = out_q;
  assign channel_interrupt_flag_o = flag_q;
  assign sync_out_o = sync_out_q;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (reset_i);

  sync_clear_a: assert property ( // [R1]
    running && !trigger_not_sync_select_q && sync_evt
    |=> channel_timer_q == '0)
    else $error("timer not cleared by sync");

  trig_hold_a: assert property ( // [R2]
    trigger_not_sync_select_q && trig_q == scou_pkg::TRG_HELD
    |=> channel_timer_q == '0)
    else $error("timer ran before trigger");

  free_run_a: assert property ( // [R5]
    running && sync_source_select_q == `SCOU_SEL_NONE &&
    $stable(compare_mode_code_q)
    |=> channel_timer_q == $past(channel_timer_q) + 1'b1)
    else $error("free-running timer did not count");

  self_reset_a: assert property ( // [R6]
    running && !trigger_not_sync_select_q &&
    sync_source_select_q == `SCOU_SEL_SELF && own_eq
    |=> channel_timer_q == '0)
    else $error("timer not reset at secondary value");

  sync_pulse_a: assert property ( // [R7]
    running && own_eq |=> sync_out_o)
    else $error("no sync pulse at secondary match");

  set_high_a: assert property ( // [R8]
    match && compare_mode_code_q == scou_pkg::MODE_SET_HIGH &&
    !wr_ctrl1 && !wr_stat |=> compare_output_pin_o)
    else $error("output not high after match");

  toggle_a: assert property ( // [R13]
    match && compare_mode_code_q == scou_pkg::MODE_TOGGLE &&
    !wr_ctrl1 && !wr_stat
    |=> compare_output_pin_o != $past(compare_output_pin_o))
    else $error("output did not toggle one clock after match");

  off_idle_a: assert property ( // [R11]
    compare_mode_code_q == scou_pkg::MODE_OFF && !wr_ctrl1
    |=> channel_timer_q == '0 && !match)
    else $error("disabled channel still running");

  flag_delay_a: assert property ( // [R16]
    chg && !wr_ctrl1 && !wr_stat |-> ##3 channel_interrupt_flag_o)
    else $error("flag not set two clocks after pin change");

  flag_cause_a: assert property ( // [R12]
    $rose(channel_interrupt_flag_o) |-> $past(chg, 3))
    else $error("flag set without output change");

  level_hold_a: assert property ( // [R14]
    compare_mode_code_q == scou_pkg::MODE_SET_LOW &&
    !compare_output_pin_o && !wr_ctrl1
    |=> !compare_output_pin_o)
    else $error("set-low output left its level");

  set_low_a: assert property ( // [R9]
    match && compare_mode_code_q == scou_pkg::MODE_SET_LOW && !wr_ctrl1
    |=> !compare_output_pin_o)
    else $error("output not low after match");

  init_level_a: assert property ( // [R8]
    wr_ctrl1
    |=> compare_output_pin_o == (compare_mode_code_q == scou_pkg::MODE_SET_LOW))
    else $error("mode write did not set the starting level");

  trig_start_a: assert property ( // [R2]
    trigger_not_sync_select_q && trig_q == scou_pkg::TRG_HELD && sync_evt
    |=> trig_q == scou_pkg::TRG_RUN)
    else $error("trigger pulse did not start the timer");

endmodule

/* verification/scou_peer_model.sv */
// peer module model issuing periodic sync pulses on one source line
module scou_peer_model (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic enable_i,
  input wire logic [4:0] src_i,
  input wire logic [7:0] gap_i,
  output logic [31:0] peer_sync_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_q;
  // one-cycle pulses; lines sit low between them, as idle pulse lines do
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_q <= 8'h00;
      peer_sync_o <= '0;
    end else begin
      peer_sync_o <= '0;
      if (enable_i && cnt_q == 8'h00) peer_sync_o[src_i] <= 1'b1;
      cnt_q <= (cnt_q >= gap_i) ? 8'h00 : cnt_q + 8'h01;
    end
  end
endmodule

/* verification/single_compare_output_unit_tb_top.sv */
// self-checking bench for the single compare output unit
`include "scou_map.svh"
module single_compare_output_unit_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  scou_pkg::scou_apb_req_s req = '0;
  scou_pkg::scou_apb_rsp_s rsp;
  logic [31:0] psync;
  logic pin;
  logic flag;
  logic sout;
  logic p_en = 1'b0;
  logic [31:0] rd_v;
  logic err_v;
  int n_errors = 0;
  int cmp_count = 0;
  int w;

  scou_unit DUT (.sys_clk_i(clk), .reset_i(rst), .apb_req_i(req), .apb_rsp_o(rsp),
    .peer_sync_i(psync), .compare_output_pin_o(pin), .channel_interrupt_flag_o(flag),
    .sync_out_o(sout));
  scou_peer_model peer (.sys_clk_i(clk), .reset_i(rst), .enable_i(p_en), .src_i(5'h05),
    .gap_i(8'h03), .peer_sync_o(psync));

  initial forever #5 clk = ~clk;

  task end_sim;
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
      n_errors++;
    end
  endtask

  task bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    // start on an edge even when called between edges
    @(posedge clk);
    req.psel <= 1'b1;
    req.pwrite <= wr;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge clk);
    req.penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge clk);
      if (rsp.pready === 1'b1) break;
    end
    rd_v = rsp.prdata;
    err_v = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge clk);
    if (i == 16) begin
      n_errors++;
      end_sim();
    end
  endtask

  task hold(input logic exp, input int n);
    repeat (n) begin
      @(posedge clk);
      #1 cmp(pin, exp);
    end
  endtask

  // bounded wait on the pin (s=0) or the sync pulse (s=1); w counts edges
  task wait_for(input bit s, input logic exp);
    #1;
    for (w = 0; w < 40; w++) begin
      if ((s ? sout : pin) === exp) break;
      @(posedge clk);
      #1;
    end
    if (w == 40) begin
      n_errors++;
      end_sim();
    end
  endtask

  task t_reset;
    bus(0, `SCOU_OFF_CTRL1, 0);
    cmp(rd_v, 0);
    cmp({pin, flag, sout}, 0);
    bus(0, 12'h0f0, 0);
    cmp(rd_v, 0);
    cmp(err_v, 1);
    $display("reset test done");
  endtask

  task t_toggle;
    bus(1, `SCOU_OFF_PRIM, 2);
    bus(1, `SCOU_OFF_CTRL1, 3);
    @(posedge clk);
    #1 cmp(pin, 0);
    @(posedge clk);
    #1 cmp(pin, 1);
    @(posedge clk);
    #1 cmp(flag, 0);
    @(posedge clk);
    #1 cmp(flag, 1);
    // in toggle mode a status write also sets the level: keep it high
    bus(1, `SCOU_OFF_STAT, 3);
    bus(0, `SCOU_OFF_STAT, 0);
    cmp(rd_v[1:0], 2'h2);
    bus(1, `SCOU_OFF_CTRL1, 0);
    bus(1, `SCOU_OFF_SEC, 4);
    bus(1, `SCOU_OFF_CTRL2, `SCOU_SEL_SELF);
    bus(1, `SCOU_OFF_PRIM, 4);
    bus(1, `SCOU_OFF_CTRL1, 3);
    wait_for(0, 1);
    wait_for(0, 0);
    cmp(w, 5);
    wait_for(1, 1);
    @(posedge clk);
    #1 wait_for(1, 1);
    cmp(w + 1, 5);
    bus(1, `SCOU_OFF_PRIM, 10);
    bus(1, `SCOU_OFF_STAT, 2);
    hold(1, 30);
    bus(1, `SCOU_OFF_STAT, 0);
    hold(0, 10);
    $display("toggle test done");
  endtask

  task t_set;
    bus(1, `SCOU_OFF_CTRL1, 2);
    bus(1, `SCOU_OFF_STAT, 1);
    hold(1, 30);
    cmp(flag, 0);
    bus(1, `SCOU_OFF_PRIM, 2);
    wait_for(0, 0);
    hold(0, 30);
    cmp(flag, 1);
    // park the timer at zero so the first match comes one clock after the check
    bus(1, `SCOU_OFF_CTRL1, 0);
    bus(1, `SCOU_OFF_STAT, 1);
    bus(1, `SCOU_OFF_CTRL1, 1);
    #1 cmp(pin, 0);
    wait_for(0, 1);
    bus(1, `SCOU_OFF_STAT, 1);
    bus(1, `SCOU_OFF_PRIM, 0);
    hold(1, 20);
    cmp(flag, 0);
    $display("set test done");
  endtask

  task t_peer;
    bus(1, `SCOU_OFF_CTRL1, 0);
    bus(1, `SCOU_OFF_CTRL2, 5);
    bus(1, `SCOU_OFF_PRIM, 6);
    p_en <= 1'b1;
    bus(1, `SCOU_OFF_CTRL1, 3);
    hold(0, 40);
    p_en <= 1'b0;
    wait_for(0, 1);
    bus(1, `SCOU_OFF_CTRL1, 0);
    bus(1, `SCOU_OFF_PRIM, 0);
    bus(1, `SCOU_OFF_CTRL2, 32'h85);
    bus(1, `SCOU_OFF_CTRL1, 1);
    hold(0, 30);
    bus(0, `SCOU_OFF_TIMER, 0);
    cmp(rd_v, 0);
    p_en <= 1'b1;
    wait_for(0, 1);
    p_en <= 1'b0;
    // any mode write but set-low (010) restarts the level at zero, off included
    bus(1, `SCOU_OFF_CTRL1, 0);
    hold(0, 20);
    bus(0, `SCOU_OFF_TIMER, 0);
    cmp(rd_v, 0);
    $display("peer test done");
  endtask

  task t_rerun;
    cmp(flag, 1);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1 cmp({pin, flag, sout}, 0);
    bus(0, `SCOU_OFF_CTRL2, 0);
    cmp(rd_v, 0);
    $display("reset rerun test done");
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_toggle();
    t_set();
    t_peer();
    t_rerun();
    end_sim();
  end
endmodule
